// *** core/mmac_defines.svh ***
// Constants of the metering mode and accumulation configuration block.
// Assumes inclusion by bare name from the block and its package.
`ifndef MMAC_DEFINES_SVH
`define MMAC_DEFINES_SVH

// Register byte addresses on the host register port
`define MMAC_MEAS_MODE_ADDR   16'he700
`define MMAC_ACC_MODE_ADDR    16'he701

// Reset values: all three phases take part in peak detection
`define MMAC_MEAS_MODE_RST    8'h1c
`define MMAC_ACC_MODE_RST     8'h00

// Measurement mode fields
`define MMAC_ACT_REV_SEL_BIT  0
`define MMAC_REA_REV_SEL_BIT  1
`define MMAC_PEAK_LSB         2
`define MMAC_PEAK_MSB         4

// Accumulation mode fields
`define MMAC_ACT_ACC_LSB      0
`define MMAC_ACT_ACC_MSB      1
`define MMAC_REA_ACC_LSB      2
`define MMAC_REA_ACC_MSB      3

// Accumulation codes
`define MMAC_ACC_SIGNED       2'h0
`define MMAC_ACC_POS          2'h1
`define MMAC_ACC_ALT          2'h2
`define MMAC_ACC_ABS          2'h3

// First status register positions of the reverse power flags
`define MMAC_ACT_REV_LSB      6
`define MMAC_REA_REV_LSB      10
`define MMAC_STAT_W           13

// Datapath widths
`define MMAC_PW               24
`define MMAC_IW               25

`endif

// *** core/mmac_pkg.sv ***
// Types shared by the accumulation configuration block and its users.
// Assumes mmac_defines.svh is on the include path.
`include "mmac_defines.svh"

package mmac_pkg;

	// One phase of power samples from the metering datapath
	typedef struct packed {
		logic signed [`MMAC_PW-1:0] tot_act;
		logic signed [`MMAC_PW-1:0] fund_act;
		logic signed [`MMAC_PW-1:0] tot_rea;
		logic signed [`MMAC_PW-1:0] fund_rea;
	} mmac_pwr_t;

	// Total and fundamental increment of one quantity
	typedef struct packed {
		logic signed [`MMAC_IW-1:0] tot;
		logic signed [`MMAC_IW-1:0] fund;
	} mmac_pair_t;

	// Conditioned increments of one phase
	typedef struct packed {
		mmac_pair_t act_reg;
		mmac_pair_t act_cf;
		mmac_pair_t rea_reg;
		mmac_pair_t rea_cf;
	} mmac_inc_t;

endpackage

// *** core/mmac_config.sv ***
// Measurement mode and accumulation mode registers of a polyphase
// energy metering core, with the power conditioning that they steer.
// Assumes power samples arrive from logic on clk, one strobe per update.
`timescale 1ns/1ns
`include "mmac_defines.svh"

// Function
// - Active reverse flags of phases A, B, C sit at status bits 6, 7, 8.
// - Active reverse select 0 uses total, 1 uses fundamental active power.
// - Reactive reverse flags of phases A, B, C sit at status bits 10-12.
// - Reactive reverse select 0 uses total, 1 fundamental reactive power.
// - Mode bits 2, 3, 4 include phases A, B, C in peak detection; reset 1.
// - Mode bits 7 to 5 reset to zero and steer nothing.
// - Active code 00 accumulates signed for energy and pulses.
// - Active code 01: energy positive only, pulses stay signed.
// - Active code 10 behaves exactly like code 00.
// - Active code 11 accumulates absolute values for energy and pulses.
// - Reactive code 00 accumulates signed for energy and pulses.
// - Reactive code 01 behaves exactly like code 00.
// - Reactive code 10 flips reactive sign while active power is negative.
// - Reactive code 11 accumulates absolute reactive values.
module mmac_config (
	// Clock and reset
	input  wire logic                                clk,
	input  wire logic                                rst,
	// Host register port
	input  wire logic [15:0]                         reg_addr,
	input  wire logic [7:0]                          reg_wr_data,
	input  wire logic                                reg_wr,
	input  wire logic                                reg_rd,
	output logic      [7:0]                          reg_rd_data_reg,
	// Power samples from the datapath
	input  wire logic                                sample_valid,
	input  wire mmac_pkg::mmac_pwr_t [2:0]           phase_pwr,
	// Reverse power flags of the first status register
	input  wire logic [`MMAC_STAT_W-1:0]             stat_clr,
	output logic      [`MMAC_STAT_W-1:0]             rev_status_reg,
	// Peak detection phase enables
	output logic      [2:0]                          peak_phase_include_reg,
	// Conditioned increments for energy registers and pulse outputs
	output logic                                     inc_valid_reg,
	output mmac_pkg::mmac_inc_t [2:0]                inc_reg
);

	// Stored fields
	logic       active_reverse_source_sel_reg;
	logic       reactive_reverse_source_sel_reg;
	logic [1:0] active_accum_field_reg;
	logic [1:0] reactive_accum_field_reg;

	// Address decode
	wire logic hit_meas;
	wire logic hit_acc;
	wire logic wr_meas;
	wire logic wr_acc;
	wire logic [7:0] meas_rd_val;
	wire logic [7:0] acc_rd_val;
	wire logic [7:0] reg_rd_data_next;

	assign hit_meas = (reg_addr == `MMAC_MEAS_MODE_ADDR);
	assign hit_acc  = (reg_addr == `MMAC_ACC_MODE_ADDR);
	assign wr_meas  = reg_wr & hit_meas;
	assign wr_acc   = reg_wr & hit_acc;

	// Upper bits are not stored, so they always read as zero
	assign meas_rd_val = {3'h0, peak_phase_include_reg,
		reactive_reverse_source_sel_reg,
		active_reverse_source_sel_reg};
	assign acc_rd_val  = {4'h0, reactive_accum_field_reg,
		active_accum_field_reg};

	// Unmapped reads answer zero
	assign reg_rd_data_next = !reg_rd  ? 8'h00 :
		hit_meas ? meas_rd_val :
		hit_acc  ? acc_rd_val  : 8'h00;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rd_data_reg <= 8'h00;
		end else begin
			reg_rd_data_reg <= reg_rd_data_next;
		end
	end

	// Measurement mode register
	localparam logic [7:0] MEAS_RST = `MMAC_MEAS_MODE_RST;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			active_reverse_source_sel_reg   <= MEAS_RST[`MMAC_ACT_REV_SEL_BIT];
			reactive_reverse_source_sel_reg <= MEAS_RST[`MMAC_REA_REV_SEL_BIT];
			peak_phase_include_reg          <=
				MEAS_RST[`MMAC_PEAK_MSB:`MMAC_PEAK_LSB];
		end else if (wr_meas) begin
			active_reverse_source_sel_reg   <=
				reg_wr_data[`MMAC_ACT_REV_SEL_BIT];
			reactive_reverse_source_sel_reg <=
				reg_wr_data[`MMAC_REA_REV_SEL_BIT];
			peak_phase_include_reg          <=
				reg_wr_data[`MMAC_PEAK_MSB:`MMAC_PEAK_LSB];
		end
	end

	// Accumulation mode register
	localparam logic [7:0] ACC_RST = `MMAC_ACC_MODE_RST;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			active_accum_field_reg   <=
				ACC_RST[`MMAC_ACT_ACC_MSB:`MMAC_ACT_ACC_LSB];
			reactive_accum_field_reg <=
				ACC_RST[`MMAC_REA_ACC_MSB:`MMAC_REA_ACC_LSB];
		end else if (wr_acc) begin
			active_accum_field_reg   <=
				reg_wr_data[`MMAC_ACT_ACC_MSB:`MMAC_ACT_ACC_LSB];
			reactive_accum_field_reg <=
				reg_wr_data[`MMAC_REA_ACC_MSB:`MMAC_REA_ACC_LSB];
		end
	end

	// Conditioning functions
	function automatic logic signed [`MMAC_IW-1:0] ext(
		input logic signed [`MMAC_PW-1:0] v);
		ext = {v[`MMAC_PW-1], v};
	endfunction

	// Widened first, so the most negative sample has a magnitude
	function automatic logic signed [`MMAC_IW-1:0] mag(
		input logic signed [`MMAC_PW-1:0] v);
		logic signed [`MMAC_IW-1:0] w;
		w = ext(v);
		mag = w[`MMAC_IW-1] ? -w : w;
	endfunction

	function automatic logic signed [`MMAC_IW-1:0] act_to_reg(
		input logic signed [`MMAC_PW-1:0] p,
		input logic [1:0] mode);
		case (mode)
			`MMAC_ACC_POS: act_to_reg = p[`MMAC_PW-1] ? '0 : ext(p);
			`MMAC_ACC_ABS: act_to_reg = mag(p);
			default:       act_to_reg = ext(p);
		endcase
	endfunction

	// Pulses stay signed in positive only mode
	function automatic logic signed [`MMAC_IW-1:0] act_to_cf(
		input logic signed [`MMAC_PW-1:0] p,
		input logic [1:0] mode);
		case (mode)
			`MMAC_ACC_ABS: act_to_cf = mag(p);
			default:       act_to_cf = ext(p);
		endcase
	endfunction

	// Zero active power counts as positive
	function automatic logic signed [`MMAC_IW-1:0] rea_cond(
		input logic signed [`MMAC_PW-1:0] q,
		input logic signed [`MMAC_PW-1:0] p,
		input logic [1:0] mode);
		case (mode)
			`MMAC_ACC_ALT:
				rea_cond = p[`MMAC_PW-1] ? -ext(q) : ext(q);
			`MMAC_ACC_ABS: rea_cond = mag(q);
			default:       rea_cond = ext(q);
		endcase
	endfunction

	// Increment strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			inc_valid_reg <= 1'b0;
		end else begin
			inc_valid_reg <= sample_valid;
		end
	end

	// Sign of the selected power at the previous update, per phase
	logic [2:0] act_sign_reg;
	logic [2:0] rea_sign_reg;
	wire logic [2:0] act_sign_now;
	wire logic [2:0] rea_sign_now;
	wire logic [2:0] act_rev_evt;
	wire logic [2:0] rea_rev_evt;

	genvar ph;
	generate
		for (ph = 0; ph < 3; ph++) begin : g_phase
			mmac_pkg::mmac_inc_t inc_next;

			// Source of each phase's reverse power detection
			assign act_sign_now[ph] = active_reverse_source_sel_reg ?
				phase_pwr[ph].fund_act[`MMAC_PW-1] :
				phase_pwr[ph].tot_act[`MMAC_PW-1];
			assign rea_sign_now[ph] = reactive_reverse_source_sel_reg ?
				phase_pwr[ph].fund_rea[`MMAC_PW-1] :
				phase_pwr[ph].tot_rea[`MMAC_PW-1];
			assign act_rev_evt[ph] = sample_valid &
				(act_sign_now[ph] != act_sign_reg[ph]);
			assign rea_rev_evt[ph] = sample_valid &
				(rea_sign_now[ph] != rea_sign_reg[ph]);

			// Live fields are used, so a write counts from the next update
			assign inc_next.act_reg.tot  = act_to_reg(
				phase_pwr[ph].tot_act, active_accum_field_reg);
			assign inc_next.act_reg.fund = act_to_reg(
				phase_pwr[ph].fund_act, active_accum_field_reg);
			assign inc_next.act_cf.tot   = act_to_cf(
				phase_pwr[ph].tot_act, active_accum_field_reg);
			assign inc_next.act_cf.fund  = act_to_cf(
				phase_pwr[ph].fund_act, active_accum_field_reg);
			assign inc_next.rea_reg.tot  = rea_cond(phase_pwr[ph].tot_rea,
				phase_pwr[ph].tot_act, reactive_accum_field_reg);
			assign inc_next.rea_reg.fund = rea_cond(phase_pwr[ph].fund_rea,
				phase_pwr[ph].fund_act, reactive_accum_field_reg);
			// Reactive pulses follow the same conditioning as the registers
			assign inc_next.rea_cf       = inc_next.rea_reg;

			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					inc_reg[ph]      <= '0;
					act_sign_reg[ph] <= 1'b0;
					rea_sign_reg[ph] <= 1'b0;
				end else if (sample_valid) begin
					inc_reg[ph]      <= inc_next;
					act_sign_reg[ph] <= act_sign_now[ph];
					rea_sign_reg[ph] <= rea_sign_now[ph];
				end
			end
		end
	endgenerate

	// Flags sit in their status positions; a new event beats a clear
	wire logic [`MMAC_STAT_W-1:0] rev_set;
	wire logic [`MMAC_STAT_W-1:0] rev_status_next;

	assign rev_set = ({{(`MMAC_STAT_W-3){1'b0}}, act_rev_evt}
			<< `MMAC_ACT_REV_LSB)
		| ({{(`MMAC_STAT_W-3){1'b0}}, rea_rev_evt}
			<< `MMAC_REA_REV_LSB);
	assign rev_status_next = (rev_status_reg & ~stat_clr) | rev_set;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rev_status_reg <= '0;
		end else begin
			rev_status_reg <= rev_status_next;
		end
	end

	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_meas_reserved_read: assert property (
		reg_rd && hit_meas |=> reg_rd_data_reg[7:5] == 3'h0
	) else $error("measurement mode reserved bits read nonzero");

	a_peak_write_follow: assert property (
		wr_meas |=> peak_phase_include_reg ==
			$past(reg_wr_data[`MMAC_PEAK_MSB:`MMAC_PEAK_LSB])
	) else $error("peak include bits do not follow the write");

	a_act_flag_total: assert property (
		sample_valid && !active_reverse_source_sel_reg &&
		phase_pwr[0].tot_act[`MMAC_PW-1] != act_sign_reg[0]
		|=> rev_status_reg[`MMAC_ACT_REV_LSB]
	) else $error("phase A active reverse flag missed");

	a_rea_flag_fund: assert property (
		sample_valid && reactive_reverse_source_sel_reg &&
		phase_pwr[2].fund_rea[`MMAC_PW-1] != rea_sign_reg[2]
		|=> rev_status_reg[`MMAC_REA_REV_LSB+2]
	) else $error("phase C reactive reverse flag missed");

	a_act_signed_mode: assert property (
		sample_valid && !active_accum_field_reg[0]
		|=> inc_reg[0].act_reg.tot == ext($past(phase_pwr[0].tot_act)) &&
			inc_reg[0].act_cf.tot == inc_reg[0].act_reg.tot
	) else $error("signed active accumulation wrong");

	a_act_pos_only: assert property (
		sample_valid && active_accum_field_reg == `MMAC_ACC_POS &&
		phase_pwr[1].fund_act[`MMAC_PW-1]
		|=> inc_reg[1].act_reg.fund == '0 &&
			inc_reg[1].act_cf.fund == ext($past(phase_pwr[1].fund_act))
	) else $error("positive only active accumulation wrong");

	a_act_abs_mode: assert property (
		sample_valid && active_accum_field_reg == `MMAC_ACC_ABS
		|=> !inc_reg[2].act_reg.tot[`MMAC_IW-1] &&
			!inc_reg[2].act_cf.tot[`MMAC_IW-1]
	) else $error("absolute active accumulation gave a negative value");

	a_rea_signed_mode: assert property (
		sample_valid && !reactive_accum_field_reg[1]
		|=> inc_reg[0].rea_reg.tot == ext($past(phase_pwr[0].tot_rea)) &&
			inc_reg[0].rea_cf.tot == inc_reg[0].rea_reg.tot
	) else $error("signed reactive accumulation wrong");

	a_rea_sign_follow: assert property (
		sample_valid && reactive_accum_field_reg == `MMAC_ACC_ALT &&
		phase_pwr[1].tot_act[`MMAC_PW-1]
		|=> inc_reg[1].rea_reg.tot == -ext($past(phase_pwr[1].tot_rea))
	) else $error("reactive sign not reversed for negative active power");

	a_rea_abs_mode: assert property (
		sample_valid && reactive_accum_field_reg == `MMAC_ACC_ABS
		|=> !inc_reg[2].rea_reg.fund[`MMAC_IW-1] &&
			!inc_reg[2].rea_cf.fund[`MMAC_IW-1]
	) else $error("absolute reactive accumulation gave a negative value");

	a_acc_write_apply: assert property (
		wr_acc |=> active_accum_field_reg == $past(reg_wr_data[1:0]) &&
			reactive_accum_field_reg == $past(reg_wr_data[3:2])
	) else $error("accumulation fields not taken from the write");

	a_flag_set_wins: assert property (
		act_rev_evt[1] && stat_clr[`MMAC_ACT_REV_LSB+1]
		|=> rev_status_reg[`MMAC_ACT_REV_LSB+1]
	) else $error("reverse flag lost against a clear");

	a_act_flag_fund: assert property (
		sample_valid && active_reverse_source_sel_reg &&
		phase_pwr[2].fund_act[`MMAC_PW-1] != act_sign_reg[2]
		|=> rev_status_reg[`MMAC_ACT_REV_LSB+2]
	) else $error("phase C active reverse flag missed");

	a_rea_flag_total: assert property (
		sample_valid && !reactive_reverse_source_sel_reg &&
		phase_pwr[2].tot_rea[`MMAC_PW-1] != rea_sign_reg[2]
		|=> rev_status_reg[`MMAC_REA_REV_LSB+2]
	) else $error("phase C reactive reverse flag missed");

	a_rea_keep_positive: assert property (
		sample_valid && reactive_accum_field_reg == `MMAC_ACC_ALT &&
		!phase_pwr[0].fund_act[`MMAC_PW-1]
		|=> inc_reg[0].rea_reg.fund == ext($past(phase_pwr[0].fund_rea)) &&
			inc_reg[0].rea_cf.fund == inc_reg[0].rea_reg.fund
	) else $error("reactive sign changed for positive active power");

	// Increments stand until the next sample
	a_inc_hold: assert property (
		!sample_valid |=> $stable(inc_reg) && !inc_valid_reg
	) else $error("increments changed without a sample");

	// Read data stands one cycle only, zero otherwise
	a_read_data_idle: assert property (
		!reg_rd |=> reg_rd_data_reg == 8'h00
	) else $error("read data present without a read strobe");

endmodule // mmac_config

// *** core/mmac_config_note_unused.sv ***
`timescale 1ns/1ns

// *** bench/tb_mmac_config.sv ***
// Self-checking bench of the mode and accumulation configuration block.
// Assumes the design files under core/ and mmac_defines.svh on include path.
`timescale 1ns/1ns
`include "mmac_defines.svh"

module tb_mmac_config;
	localparam int TIMEOUT = 3000;

	logic                          clk;
	logic                          rst;
	logic [15:0]                   reg_addr;
	logic [7:0]                    reg_wr_data;
	logic                          reg_wr;
	logic                          reg_rd;
	logic [7:0]                    reg_rd_data_reg;
	logic                          sample_valid;
	mmac_pkg::mmac_pwr_t [2:0]     phase_pwr;
	logic [`MMAC_STAT_W-1:0]       stat_clr;
	logic [`MMAC_STAT_W-1:0]       rev_status_reg;
	logic [2:0]                    peak_phase_include_reg;
	logic                          inc_valid_reg;
	mmac_pkg::mmac_inc_t [2:0]     inc_reg;
	int                            n_errors = 0;
	int                            check_count = 0;
	int                            cycle_count = 0;

	mmac_config mmac_config_i (
		.clk                    (clk),
		.rst                    (rst),
		.reg_addr               (reg_addr),
		.reg_wr_data            (reg_wr_data),
		.reg_wr                 (reg_wr),
		.reg_rd                 (reg_rd),
		.reg_rd_data_reg        (reg_rd_data_reg),
		.sample_valid           (sample_valid),
		.phase_pwr              (phase_pwr),
		.stat_clr               (stat_clr),
		.rev_status_reg         (rev_status_reg),
		.peak_phase_include_reg (peak_phase_include_reg),
		.inc_valid_reg          (inc_valid_reg),
		.inc_reg                (inc_reg)
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// A hang counts as a mismatch
	always @(posedge clk) begin
		cycle_count <= cycle_count + 1;
		if (cycle_count == TIMEOUT) begin
			n_errors++;
			stop_test();
		end
	end

	task automatic check(logic [31:0] seen, logic [31:0] exp, string msg);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: %s seen %h expected %h",
				$time, msg, seen, exp);
		end
	endtask

	task automatic reg_write(logic [15:0] a, logic [7:0] d);
		@(posedge clk);
		reg_addr    <= a;
		reg_wr_data <= d;
		reg_wr      <= 1'b1;
		@(posedge clk);
		reg_wr      <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic reg_read(logic [15:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1;
		d = reg_rd_data_reg;
	endtask

	task automatic set_pwr(int ph, logic [23:0] ta, logic [23:0] fa,
		logic [23:0] tr, logic [23:0] fr);
		@(posedge clk);
		phase_pwr[ph] <= '{tot_act: ta, fund_act: fa, tot_rea: tr,
			fund_rea: fr};
	endtask

	task automatic send_sample();
		@(posedge clk);
		sample_valid <= 1'b1;
		@(posedge clk);
		sample_valid <= 1'b0;
		#1;
		check(inc_valid_reg, 1, "increment strobe");
		@(posedge clk);
		#1;
		check(inc_valid_reg, 0, "increment strobe ends");
	endtask

	task automatic clear_flags(logic [`MMAC_STAT_W-1:0] m);
		@(posedge clk);
		stat_clr <= m;
		@(posedge clk);
		stat_clr <= '0;
		#1;
	endtask

	function automatic logic signed [24:0] act_exp(logic signed [23:0] p,
		logic [1:0] c, bit cf);
		logic signed [24:0] w;
		w = p;
		if (c == 2'h3 && w < 0)
			return -w;
		if (c == 2'h1 && !cf && w < 0)
			return 25'h000_0000;
		return w;
	endfunction

	function automatic logic signed [24:0] rea_exp(logic signed [23:0] q,
		logic signed [23:0] p, logic [1:0] c);
		logic signed [24:0] w;
		w = q;
		if (c == 2'h3 && w < 0)
			return -w;
		if (c == 2'h2 && p < 0)
			return -w;
		return w;
	endfunction

	task automatic test_reset_and_map();
		logic [7:0] d;
		check(peak_phase_include_reg, 3'h7, "peak reset");
		reg_read(`MMAC_MEAS_MODE_ADDR, d);
		check(d, 8'h1c, "measurement mode reset");
		reg_read(`MMAC_ACC_MODE_ADDR, d);
		check(d, 8'h00, "accumulation mode reset");
		reg_write(16'he702, 8'hff);
		reg_read(16'he702, d);
		check(d, 8'h00, "unmapped read");
		reg_write(`MMAC_MEAS_MODE_ADDR, 8'hff);
		reg_read(`MMAC_MEAS_MODE_ADDR, d);
		check(d, 8'h1f, "reserved bits ignore writes");
		for (int i = 0; i < 3; i++) begin
			reg_write(`MMAC_MEAS_MODE_ADDR, 8'h1c ^ (8'h04 << i));
			#1;
			check(peak_phase_include_reg, 3'h7 ^ (3'h1 << i),
				"peak phase drop");
		end
		reg_write(`MMAC_MEAS_MODE_ADDR, 8'h1c);
		$display("test reset_and_map done");
	endtask

	task automatic test_accumulation();
		logic signed [23:0] ta, fa, tr, fr;
		ta = 24'h80_0000;
		fa = 24'h00_0007;
		tr = 24'hff_fffd;
		fr = 24'hff_fff7;
		for (int ph = 0; ph < 3; ph++)
			set_pwr(ph, ta, fa, tr, fr);
		for (int c = 0; c < 16; c++) begin
			// Write and sample back to back: the new code must apply
			reg_write(`MMAC_ACC_MODE_ADDR, 8'(c));
			send_sample();
			for (int ph = 0; ph < 3; ph++) begin
				check(inc_reg[ph].act_reg.tot, act_exp(ta, 2'(c), 0),
					"active energy total");
				check(inc_reg[ph].act_cf.tot, act_exp(ta, 2'(c), 1),
					"active pulse total");
				check(inc_reg[ph].act_reg.fund, act_exp(fa, 2'(c), 0),
					"active energy fund");
				check(inc_reg[ph].rea_reg.tot, rea_exp(tr, ta, 2'(c >> 2)),
					"reactive total");
				check(inc_reg[ph].rea_reg.fund, rea_exp(fr, fa, 2'(c >> 2)),
					"reactive fund");
				check(inc_reg[ph].act_cf.fund, act_exp(fa, 2'(c), 1),
					"active pulse fund");
				check(inc_reg[ph].rea_cf.tot, rea_exp(tr, ta, 2'(c >> 2)),
					"reactive pulse total");
				check(inc_reg[ph].rea_cf.fund, rea_exp(fr, fa, 2'(c >> 2)),
					"reactive pulse fund");
			end
		end
		reg_write(`MMAC_ACC_MODE_ADDR, 8'h00);
		$display("test accumulation done");
	endtask

	task automatic test_reverse_flags();
		for (int ph = 0; ph < 3; ph++)
			set_pwr(ph, 24'h00_0010, 24'hff_fff0, 24'h00_0020, 24'hff_ffe0);
		send_sample();
		send_sample();
		clear_flags(13'h1fff);
		check(rev_status_reg, 13'h0000, "flags cleared");
		set_pwr(1, 24'hff_fff0, 24'hff_fff0, 24'h00_0020, 24'hff_ffe0);
		set_pwr(2, 24'h00_0010, 24'hff_fff0, 24'hff_ffe0, 24'hff_ffe0);
		send_sample();
		check(rev_status_reg, 13'h1080, "totals");
		clear_flags(13'h0080);
		check(rev_status_reg, 13'h1000, "single flag clear");
		// Fundamental source: only fundamental sign changes may flag
		reg_write(`MMAC_MEAS_MODE_ADDR, 8'h1f);
		send_sample();
		send_sample();
		clear_flags(13'h1fff);
		set_pwr(0, 24'h00_0010, 24'h00_0010, 24'h00_0020, 24'h00_0020);
		set_pwr(2, 24'hff_fff0, 24'hff_fff0, 24'h00_0020, 24'hff_ffe0);
		send_sample();
		check(rev_status_reg, 13'h0440, "funds");
		reg_write(`MMAC_MEAS_MODE_ADDR, 8'h1c);
		$display("test reverse_flags done");
	endtask

	// A sign change and a clear of the same flag in one cycle
	task automatic test_set_beats_clear();
		send_sample();
		send_sample();
		clear_flags(13'h1fff);
		check(rev_status_reg, 13'h0000, "flags settle");
		set_pwr(1, 24'h00_0010, 24'hff_fff0, 24'h00_0020, 24'hff_ffe0);
		@(posedge clk);
		sample_valid <= 1'b1;
		stat_clr     <= 13'h0080;
		@(posedge clk);
		sample_valid <= 1'b0;
		stat_clr     <= '0;
		#1;
		check(rev_status_reg, 13'h0080, "set beats clear");
		$display("test set_beats_clear done");
	endtask

	initial begin
		rst          = 1'b1;
		reg_addr     = 16'h0000;
		reg_wr_data  = 8'h00;
		reg_wr       = 1'b0;
		reg_rd       = 1'b0;
		sample_valid = 1'b0;
		phase_pwr    = '0;
		stat_clr     = '0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		test_reset_and_map();
		test_accumulation();
		test_reverse_flags();
		test_set_beats_clear();
		stop_test();
	end
endmodule // tb_mmac_config
